// ### hdl/icf_regs.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module icf_regs
	import icf_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// register bus
	input  wire icf_axil_req_type   s_axi_req,
	output var  icf_axil_rsp_type   s_axi_rsp,
	// request sources
	input  wire icf_flags0_type     periph_flags0_req,
	input  wire icf_flags1_type     periph_flags1_req,
	input  wire logic [EXT_NUM-1:0] ext_pin_in,
	// cpu side
	input  wire logic               timed_irq_disable_active,
	output logic                    alt_vector_table_select,
	output var  icf_flags0_type     flags0_out,
	output var  icf_flags1_type     flags1_out,
	output logic [EXT_NUM-1:0]      ext_edge_pulse,
	output logic                    irq
);
	////////////////////////////////////////////////////////////////////////
	logic                   wr_en, wr_ok, rd_take, rd_ok;
	logic [AXIL_ADDR_W-1:0] wr_addr;
	logic [AXIL_DATA_W-1:0] wr_data, rd_data;
	logic [AXIL_STRB_W-1:0] wr_strb;
	logic [REG_W-1:0]       ctrl_q, ctrl_d;
	logic [REG_W-1:0]       flags0_q, flags0_d, flags1_q, flags1_d;
	logic [REG_W-1:0]       req0_v, req1_v, set0, set1;
	logic [STAT_W-1:0]      status_q, status_d, mask_q, mask_d;
	logic                   irq_q, irq_d;
	logic                   wr_ctrl, wr_f0, wr_f1, wr_stat, wr_mask;
	logic [EXT_NUM-1:0]     ext_edge;

	function automatic logic [REG_W-1:0] merge_strb(
		input logic [REG_W-1:0] old_v,
		input logic [REG_W-1:0] new_v,
		input logic [1:0]       strb
	);
		logic [REG_W-1:0] res;
		res = old_v;
		if (strb[0]) begin
			res[7:0] = new_v[7:0];
		end
		if (strb[1]) begin
			res[15:8] = new_v[15:8];
		end
		return res;
	endfunction

	function automatic logic addr_known(input logic [AXIL_ADDR_W-1:0] a);
		return a == CTRL2_OFFS || a == FLAGS0_OFFS || a == FLAGS1_OFFS
			|| a == STAT_OFFS || a == MASK_OFFS;
	endfunction

	////////////////////////////////////////////////////////////////////////
	icf_axil_slave i_icf_axil_slave (
		.clk       (clk),
		.rst       (rst),
		.s_axi_req (s_axi_req),
		.s_axi_rsp (s_axi_rsp),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb),
		.wr_ok     (wr_ok),
		.rd_take   (rd_take),
		.rd_data   (rd_data),
		.rd_ok     (rd_ok)
	);

	icf_ext_edge #(
		.N (EXT_NUM)
	) i_icf_ext_edge (
		.clk        (clk),
		.rst        (rst),
		.pin_in     (ext_pin_in),
		.polarity   (ctrl_q[EXT_NUM-1:0]),
		.edge_pulse (ext_edge)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		wr_ok   = addr_known(wr_addr);
		wr_ctrl = wr_en && wr_addr == CTRL2_OFFS;
		wr_f0   = wr_en && wr_addr == FLAGS0_OFFS;
		wr_f1   = wr_en && wr_addr == FLAGS1_OFFS;
		wr_stat = wr_en && wr_addr == STAT_OFFS && wr_strb[0];
		wr_mask = wr_en && wr_addr == MASK_OFFS && wr_strb[0];
		req0_v  = periph_flags0_req;
		req1_v  = periph_flags1_req;
		// external flags come from the pins only, never the peripheral word
		set0 = req0_v & FLAGS0_IMPL & ~FLAGS0_EXT; // [RULE5] [RULE6]
		set1 = req1_v & FLAGS1_IMPL & ~FLAGS1_EXT; // [RULE7] [RULE8]
		set0[EXT0_FLAG_BIT] = ext_edge[0]; // [RULE12]
		set1[EXT1_FLAG_BIT] = ext_edge[1]; // [RULE12]
		set1[EXT2_FLAG_BIT] = ext_edge[2]; // [RULE12]
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = merge_strb(ctrl_q, wr_data[REG_W-1:0], wr_strb[1:0])
				& CTRL2_WMASK; // [RULE1] [RULE3] [RULE4]
		end
		flags0_d = flags0_q;
		flags1_d = flags1_q;
		if (wr_f0) begin
			flags0_d = merge_strb(flags0_q, wr_data[REG_W-1:0], wr_strb[1:0]);
		end
		if (wr_f1) begin
			flags1_d = merge_strb(flags1_q, wr_data[REG_W-1:0], wr_strb[1:0]);
		end
		// a request in the clearing cycle survives the write
		flags0_d = (flags0_d | set0) & FLAGS0_IMPL; // [RULE9] [RULE10] [RULE11]
		flags1_d = (flags1_d | set1) & FLAGS1_IMPL; // [RULE9] [RULE10] [RULE11]
		status_d = status_q;
		if (wr_stat) begin
			status_d = status_q & ~wr_data[STAT_W-1:0];
		end
		status_d = status_d | {(|set1), (|set0)};
		mask_d = wr_mask ? wr_data[STAT_W-1:0] : mask_q;
		irq_d  = |(status_d & mask_d);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q   <= REG_RESET; // [RULE10]
			flags0_q <= REG_RESET; // [RULE10]
			flags1_q <= REG_RESET; // [RULE10]
			status_q <= '0;
			mask_q   <= '0;
			irq_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			flags0_q <= flags0_d;
			flags1_q <= flags1_d;
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux looks at the live address; the slave latches the read data on take
	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		case (s_axi_req.araddr)
			CTRL2_OFFS: begin
				rd_data[REG_W-1:0] = ctrl_q; // [RULE4]
				rd_data[TDIS_BIT]  = timed_irq_disable_active; // [RULE2]
			end
			FLAGS0_OFFS: begin
				rd_data[REG_W-1:0] = flags0_q;
			end
			FLAGS1_OFFS: begin
				rd_data[REG_W-1:0] = flags1_q;
			end
			STAT_OFFS: begin
				rd_data[STAT_W-1:0] = status_q;
			end
			MASK_OFFS: begin
				rd_data[STAT_W-1:0] = mask_q;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		alt_vector_table_select = ctrl_q[ALT_VT_BIT]; // [RULE1]
		flags0_out              = flags0_q;
		flags1_out              = flags1_q;
		ext_edge_pulse          = ext_edge;
		irq                     = irq_q;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_ctrl_read;
		rd_take && s_axi_req.araddr == CTRL2_OFFS ##1 s_axi_rsp.rvalid;
	endsequence

	property p_alt_vt;
		wr_ctrl && wr_strb[1]
			|=> alt_vector_table_select == $past(wr_data[ALT_VT_BIT]);
	endproperty
	a_alt_vt: assert property (p_alt_vt) // [RULE1]
		else $error("alternate table bit not taken from write");

	property p_tdis_read;
		s_ctrl_read |-> s_axi_rsp.rdata[TDIS_BIT]
			== $past(timed_irq_disable_active);
	endproperty
	a_tdis_read: assert property (p_tdis_read) // [RULE2]
		else $error("timed disable status read wrong");

	property p_ctrl_unimpl;
		s_ctrl_read |-> s_axi_rsp.rdata[TDIS_BIT-1:EXT_NUM] == '0
			&& s_axi_rsp.rdata[AXIL_DATA_W-1:REG_W] == '0;
	endproperty
	a_ctrl_unimpl: assert property (p_ctrl_unimpl) // [RULE4]
		else $error("unimplemented control bits not zero");

	property p_conv_flag;
		periph_flags0_req.converter_done_flag
			|=> flags0_out.converter_done_flag;
	endproperty
	a_conv_flag: assert property (p_conv_flag) // [RULE5]
		else $error("converter flag not set");

	property p_timer2_flag;
		periph_flags0_req.timer_two_flag |=> flags0_out.timer_two_flag;
	endproperty
	a_timer2_flag: assert property (p_timer2_flag) // [RULE6]
		else $error("timer two flag not set");

	property p_serial2_tx;
		periph_flags1_req.serial2_tx_flag |=> flags1_out.serial2_tx_flag;
	endproperty
	a_serial2_tx: assert property (p_serial2_tx) // [RULE7]
		else $error("serial two tx flag not set");

	property p_i2c_slave;
		periph_flags1_req.i2c_one_slave_flag
			|=> flags1_out.i2c_one_slave_flag;
	endproperty
	a_i2c_slave: assert property (p_i2c_slave) // [RULE8]
		else $error("i2c slave flag not set");

	property p_unimpl_flags;
		(flags0_q & ~FLAGS0_IMPL) == '0 && (flags1_q & ~FLAGS1_IMPL) == '0;
	endproperty
	a_unimpl_flags: assert property (p_unimpl_flags) // [RULE9]
		else $error("unimplemented flag bit set");

	property p_reset_clear;
		$fell(rst) |-> flags0_q == '0 && flags1_q == '0 && ctrl_q == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // [RULE10]
		else $error("registers not zero after reset");

	property p_sw_write;
		wr_f0 && wr_strb[1:0] == 2'b11 && set0 == '0
			|=> flags0_q == ($past(wr_data[REG_W-1:0]) & FLAGS0_IMPL);
	endproperty
	a_sw_write: assert property (p_sw_write) // [RULE10]
		else $error("flag write not stored");

	property p_sticky;
		!wr_f1 ##0 flags1_q != '0
			|=> (flags1_q & $past(flags1_q)) == $past(flags1_q);
	endproperty
	a_sticky: assert property (p_sticky) // [RULE11]
		else $error("flag dropped without software clear");

	property p_ext_flag;
		ext_edge[1] ##1 !wr_f1 |-> flags1_q[EXT1_FLAG_BIT];
	endproperty
	a_ext_flag: assert property (p_ext_flag) // [RULE12]
		else $error("external flag not set after edge");

	property p_irq_level;
		irq == |(status_q & mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level wrong");

	sequence s_ext0_seen;
		ext_edge[0] ##1 !wr_f0;
	endsequence

	property p_ext0_flag;
		s_ext0_seen |-> flags0_q[EXT0_FLAG_BIT];
	endproperty
	a_ext0_flag: assert property (p_ext0_flag) // [RULE12]
		else $error("external zero flag not set after edge");

	property p_ext2_flag;
		ext_edge[2] |=> flags1_q[EXT2_FLAG_BIT];
	endproperty
	a_ext2_flag: assert property (p_ext2_flag) // [RULE12]
		else $error("external two flag not set after edge");

	// the peripheral word must not reach the pin-owned flag
	property p_ext0_pin_only;
		!ext_edge[0] && !wr_f0 && !flags0_q[EXT0_FLAG_BIT]
			|=> !flags0_q[EXT0_FLAG_BIT];
	endproperty
	a_ext0_pin_only: assert property (p_ext0_pin_only) // [RULE12]
		else $error("external zero flag set without an edge");

	property p_polarity_write;
		wr_ctrl && wr_strb[0]
			|=> ctrl_q[EXT_NUM-1:0] == $past(wr_data[EXT_NUM-1:0]);
	endproperty
	a_polarity_write: assert property (p_polarity_write) // [RULE3]
		else $error("edge polarity bits not taken from write");

	property p_bad_write;
		wr_en && !wr_ok
			|=> s_axi_rsp.bvalid && s_axi_rsp.bresp == RESP_SLVERR;
	endproperty
	a_bad_write: assert property (p_bad_write)
		else $error("unmapped write not refused");
endmodule // icf_regs
`default_nettype wire

// ### hdl/icf_pkg.sv
// Functional notes
// [RULE1] Control bit 15 is writable and selects the alternate vector table.
// [RULE2] Control bit 14 is read-only and reads one while timed disable runs.
// [RULE3] Control bits 4..0 pick the edge per external input, 1 fall, 0 rise.
// [RULE4] Control bits 13..5 are unimplemented and read as zero.
// [RULE5] Flags0 bits 13..8: converter, serial1 tx/rx, spi1 event/fault, tmr3.
// [RULE6] Flags0 bits 7,6,5,3,2,1,0: tmr2, cmp2, cap2, tmr1, cmp1, cap1, ext0.
// [RULE7] Flags1 bits 15..9: serial2 tx/rx, ext2, tmr5, tmr4, cmp4, cmp3.
// [RULE8] Flags1 bits 7,6,4..0: cap8, cap7, ext1, change, comparator, i2c1 m/s.
// [RULE9] Flags0 bits 15,14,4 and flags1 bits 8,5 read as zero.
// [RULE10] Every implemented flag is read/write and resets to zero.
// [RULE11] Sources set flags; a flag stays set until software clears it.
// [RULE12] An external flag sets the cycle after a synchronised edge is seen.
`default_nettype none
package icf_pkg;
	localparam int unsigned AXIL_ADDR_W = 8;
	localparam int unsigned AXIL_DATA_W = 32;
	localparam int unsigned AXIL_STRB_W = 4;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned EXT_NUM     = 5;
	localparam int unsigned STAT_W      = 2;
	localparam int unsigned ARM_W       = 3;
	localparam logic [AXIL_ADDR_W-1:0] CTRL2_OFFS  = 8'h00;
	localparam logic [AXIL_ADDR_W-1:0] FLAGS0_OFFS = 8'h04;
	localparam logic [AXIL_ADDR_W-1:0] FLAGS1_OFFS = 8'h08;
	localparam logic [AXIL_ADDR_W-1:0] STAT_OFFS   = 8'h0C;
	localparam logic [AXIL_ADDR_W-1:0] MASK_OFFS   = 8'h10;
	localparam int unsigned ALT_VT_BIT = 15;
	localparam int unsigned TDIS_BIT   = 14;
	localparam int unsigned EXT0_FLAG_BIT = 0;
	localparam int unsigned EXT1_FLAG_BIT = 4;
	localparam int unsigned EXT2_FLAG_BIT = 13;
	localparam logic [REG_W-1:0] CTRL2_WMASK  = 16'h801F;
	localparam logic [REG_W-1:0] FLAGS0_IMPL  = 16'h3FEF;
	localparam logic [REG_W-1:0] FLAGS1_IMPL  = 16'hFEDF;
	localparam logic [REG_W-1:0] FLAGS0_EXT   = 16'h0001;
	localparam logic [REG_W-1:0] FLAGS1_EXT   = 16'h2010;
	localparam logic [REG_W-1:0] REG_RESET    = 16'h0000;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [1:0] unused_hi;
		logic converter_done_flag;
		logic serial1_tx_flag;
		logic serial1_rx_flag;
		logic spi_one_event_flag;
		logic spi_one_fault_flag;
		logic timer_three_flag;
		logic timer_two_flag;
		logic compare_two_flag;
		logic capture_two_flag;
		logic unused_b4;
		logic timer_one_flag;
		logic compare_one_flag;
		logic capture_one_flag;
		logic ext0_request_flag;
	} icf_flags0_type;

	typedef struct packed {
		logic serial2_tx_flag;
		logic serial2_rx_flag;
		logic ext2_request_flag;
		logic timer_five_flag;
		logic timer_four_flag;
		logic compare_four_flag;
		logic compare_three_flag;
		logic unused_b8;
		logic capture_eight_flag;
		logic capture_seven_flag;
		logic unused_b5;
		logic ext1_request_flag;
		logic change_notify_flag;
		logic comparator_flag;
		logic i2c_one_master_flag;
		logic i2c_one_slave_flag;
	} icf_flags1_type;

	typedef struct packed {
		logic [AXIL_ADDR_W-1:0] awaddr;
		logic                   awvalid;
		logic [AXIL_DATA_W-1:0] wdata;
		logic [AXIL_STRB_W-1:0] wstrb;
		logic                   wvalid;
		logic                   bready;
		logic [AXIL_ADDR_W-1:0] araddr;
		logic                   arvalid;
		logic                   rready;
	} icf_axil_req_type;

	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic [1:0]             bresp;
		logic                   bvalid;
		logic                   arready;
		logic [AXIL_DATA_W-1:0] rdata;
		logic [1:0]             rresp;
		logic                   rvalid;
	} icf_axil_rsp_type;
endpackage
`default_nettype wire

// ### hdl/icf_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module icf_axil_slave
	import icf_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// bus
	input  wire icf_axil_req_type       s_axi_req,
	output var  icf_axil_rsp_type       s_axi_rsp,
	// register side
	output logic                        wr_en,
	output logic [AXIL_ADDR_W-1:0]      wr_addr,
	output logic [AXIL_DATA_W-1:0]      wr_data,
	output logic [AXIL_STRB_W-1:0]      wr_strb,
	input  wire logic                   wr_ok,
	output logic                        rd_take,
	input  wire logic [AXIL_DATA_W-1:0] rd_data,
	input  wire logic                   rd_ok
);
	logic                   aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [AXIL_ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [AXIL_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [AXIL_STRB_W-1:0] wstrb_q, wstrb_d;
	logic                   bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]             bresp_q, bresp_d, rresp_q, rresp_d;
	logic                   awready, wready;

	// address and data are parked, so either may come first
	always_comb begin
		awready   = !aw_have_q && !bvalid_q;
		wready    = !w_have_q && !bvalid_q;
		wr_en     = aw_have_q && w_have_q && !bvalid_q;
		rd_take   = s_axi_req.arvalid && !rvalid_q;
		aw_have_d = aw_have_q;
		awaddr_d  = awaddr_q;
		w_have_d  = w_have_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (s_axi_req.awvalid && awready) begin
			aw_have_d = 1'b1;
			awaddr_d  = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && wready) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_req.wdata;
			wstrb_d  = s_axi_req.wstrb;
		end
		if (wr_en) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_req.bready) begin
			bvalid_d = 1'b0;
		end
		if (rd_take) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_ok ? rd_data : '0;
			rresp_d  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_req.rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			bvalid_q  <= bvalid_d;
			rvalid_q  <= rvalid_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bresp_q   <= bresp_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	always_comb begin
		wr_addr           = awaddr_q;
		wr_data           = wdata_q;
		wr_strb           = wstrb_q;
		s_axi_rsp.awready = awready;
		s_axi_rsp.wready  = wready;
		s_axi_rsp.bresp   = bresp_q;
		s_axi_rsp.bvalid  = bvalid_q;
		s_axi_rsp.arready = !rvalid_q;
		s_axi_rsp.rdata   = rdata_q;
		s_axi_rsp.rresp   = rresp_q;
		s_axi_rsp.rvalid  = rvalid_q;
	end
endmodule // icf_axil_slave
`default_nettype wire

// ### hdl/icf_ext_edge.sv
`timescale 1ns/1ns
`default_nettype none
module icf_ext_edge
	import icf_pkg::*;
#(
	parameter int unsigned N = EXT_NUM
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// pins and edge choice
	input  wire logic [N-1:0] pin_in,
	input  wire logic [N-1:0] polarity,
	// detected edges
	output logic [N-1:0]      edge_pulse
);
	logic [N-1:0]     sync1_q, sync2_q, prev_q;
	logic [ARM_W-1:0] arm_q, arm_d;

	// arming stops a pin held high through reset looking like an edge
	always_comb begin
		arm_d = {arm_q[ARM_W-2:0], 1'b1};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
			arm_q   <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			arm_q   <= arm_d;
		end
	end

	// polarity one catches falling, zero rising
	always_comb begin
		edge_pulse = '0;
		if (arm_q[ARM_W-1]) begin
			edge_pulse = (sync2_q ^ prev_q) & (sync2_q ^ polarity); // [RULE3]
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_chk
		sequence s_rise;
			!sync2_q[i] ##1 sync2_q[i];
		endsequence
		sequence s_fall;
			sync2_q[i] ##1 !sync2_q[i];
		endsequence
		property p_rise_edge;
			@(posedge clk) disable iff (rst)
			s_rise ##0 arm_q[ARM_W-1] |-> edge_pulse[i] == !polarity[i];
		endproperty
		a_rise_edge: assert property (p_rise_edge) // [RULE3]
			else $error("rising edge decision wrong");
		property p_fall_edge;
			@(posedge clk) disable iff (rst)
			s_fall ##0 arm_q[ARM_W-1] |-> edge_pulse[i] == polarity[i];
		endproperty
		a_fall_edge: assert property (p_fall_edge) // [RULE3]
			else $error("falling edge decision wrong");
		property p_quiet_pin;
			@(posedge clk) disable iff (rst)
			$stable(sync2_q[i]) |-> !edge_pulse[i];
		endproperty
		a_quiet_pin: assert property (p_quiet_pin) // [RULE3]
			else $error("edge seen on a quiet pin");
	end
endmodule // icf_ext_edge
`default_nettype wire

// ### tb/icf_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module icf_src_model
	import icf_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// bench control
	input  wire logic               go,
	input  wire logic [31:0]        pattern,
	input  wire logic [EXT_NUM-1:0] pin_lvl,
	// toward the block
	output var  icf_flags0_type     req0,
	output var  icf_flags1_type     req1,
	output logic [EXT_NUM-1:0]      pins
);
	////////////////////////////////////////////////////////////////////////
	// one-cycle strobes, as a peripheral signals its event; unimplemented
	// and pin-owned bits are sent too, the block must drop them
	always_ff @(posedge clk) begin
		req0 <= (go && !rst) ? pattern[15:0] : 16'h0000;
		req1 <= (go && !rst) ? pattern[31:16] : 16'h0000;
		pins <= pin_lvl;
	end
endmodule // icf_src_model
`default_nettype wire

// ### tb/irq_control_and_flag_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module irq_control_and_flag_regs_bench
	import icf_pkg::*;
;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             tdis = 1'b0;
	logic             go = 1'b0;
	logic [31:0]      pat = 32'h0000_0000;
	logic [4:0]       lvl = 5'h00;
	logic [4:0]       s;
	icf_axil_req_type req = '0;
	icf_axil_rsp_type rsp;
	icf_flags0_type   p0;
	icf_flags0_type   f0o;
	icf_flags1_type   p1;
	icf_flags1_type   f1o;
	logic [4:0]       pins;
	logic [4:0]       pulse;
	logic             alt;
	logic             irq;
	logic [15:0]      m_ctrl = 16'h0000;
	logic [15:0]      m_f0 = 16'h0000;
	logic [15:0]      m_f1 = 16'h0000;
	logic [1:0]       m_st = 2'h0;
	logic [1:0]       m_mk = 2'h0;
	logic [31:0]      rdat;
	int               num_errors = 0;
	int               n_tests = 0;
	int               cyc = 0;

	icf_src_model i_icf_src_model (.clk(clk), .rst(rst), .go(go),
		.pattern(pat), .pin_lvl(lvl), .req0(p0), .req1(p1), .pins(pins));
	icf_regs i_icf_regs (.clk(clk), .rst(rst), .s_axi_req(req),
		.s_axi_rsp(rsp), .periph_flags0_req(p0), .periph_flags1_req(p1),
		.ext_pin_in(pins), .timed_irq_disable_active(tdis),
		.alt_vector_table_select(alt), .flags0_out(f0o),
		.flags1_out(f1o), .ext_edge_pulse(pulse), .irq(irq));

	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// reference model of the register file
	function automatic logic [31:0] mdl(input logic [7:0] a);
		case (a)
			CTRL2_OFFS: return {16'h0000, m_ctrl | {1'b0, tdis, 14'h0000}};
			FLAGS0_OFFS: return {16'h0000, m_f0};
			FLAGS1_OFFS: return {16'h0000, m_f1};
			STAT_OFFS: return {30'h0, m_st};
			MASK_OFFS: return {30'h0, m_mk};
			default: return 32'h0000_0000;
		endcase
	endfunction

	function automatic logic [31:0] resp_of(input logic [7:0] a);
		if (a inside {CTRL2_OFFS, FLAGS0_OFFS, FLAGS1_OFFS, STAT_OFFS,
			MASK_OFFS})
			return {30'h0, RESP_OKAY};
		return {30'h0, RESP_SLVERR};
	endfunction

	// byte lanes: strobe 0 low byte, strobe 1 high byte
	function automatic logic [15:0] mrg(input logic [15:0] o,
		input logic [15:0] n, input logic [3:0] st);
		return {st[1] ? n[15:8] : o[15:8], st[0] ? n[7:0] : o[7:0]};
	endfunction

	function automatic void mwr(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] st);
		case (a)
			CTRL2_OFFS: m_ctrl = mrg(m_ctrl, d, st) & CTRL2_WMASK;
			FLAGS0_OFFS: m_f0 = mrg(m_f0, d, st) & FLAGS0_IMPL;
			FLAGS1_OFFS: m_f1 = mrg(m_f1, d, st) & FLAGS1_IMPL;
			STAT_OFFS: if (st[0]) m_st = m_st & ~d[1:0];
			MASK_OFFS: if (st[0]) m_mk = d[1:0];
			default: ;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	// bus master; leading edge keeps a task from re-driving in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st = 4'hF);
		logic [1:0] br;
		@(posedge clk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= st;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				br = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
		chk({30'h0, br}, resp_of(a));
		mwr(a, d[15:0], st);
	endtask

	task automatic rd(input logic [7:0] a);
		logic [1:0] rs;
		@(posedge clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rdat = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
		chk({30'h0, rs}, resp_of(a));
		chk(rdat, mdl(a));
	endtask

	// outputs settle after the edge's updates land
	task automatic outs();
		#1;
		chk({16'h0000, f0o}, {16'h0000, m_f0});
		chk({16'h0000, f1o}, {16'h0000, m_f1});
		chk({31'h0, alt}, {31'h0, m_ctrl[15]});
		chk({31'h0, irq}, {31'h0, |(m_st & m_mk)});
	endtask

	task automatic fire(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] s0;
		logic [15:0] s1;
		s0 = a & FLAGS0_IMPL & ~FLAGS0_EXT;
		s1 = b & FLAGS1_IMPL & ~FLAGS1_EXT;
		@(posedge clk);
		go <= 1'b1;
		pat <= {b, a};
		@(posedge clk);
		go <= 1'b0;
		m_f0 = m_f0 | s0;
		m_f1 = m_f1 | s1;
		if (s0 != 16'h0000) m_st[0] = 1'b1;
		if (s1 != 16'h0000) m_st[1] = 1'b1;
		repeat (3) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(33));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'(4 * i));
		outs();
		rd(8'h14);
		wr(8'h14, 32'hFFFF_FFFF);
		wr(CTRL2_OFFS, 32'hFFFF_FFFF);
		rd(CTRL2_OFFS);
		outs();
		tdis <= 1'b1;
		rd(CTRL2_OFFS);
		tdis <= 1'b0;
		wr(CTRL2_OFFS, 32'h0000_0000);
		rd(CTRL2_OFFS);
		outs();
		wr(CTRL2_OFFS, 32'hFFFF_FFFF, 4'h2);
		rd(CTRL2_OFFS);
		outs();
		wr(FLAGS0_OFFS, 32'hFFFF_FFFF);
		wr(FLAGS1_OFFS, 32'hFFFF_FFFF);
		rd(FLAGS0_OFFS);
		rd(FLAGS1_OFFS);
		wr(FLAGS0_OFFS, 32'h0000_0000);
		wr(FLAGS1_OFFS, 32'h0000_0000);
		// random strobes accumulate: flags must hold until cleared
		for (int i = 0; i < 12; i++) begin
			fire(16'($urandom), 16'($urandom));
			rd(FLAGS0_OFFS);
			rd(FLAGS1_OFFS);
			outs();
		end
		wr(FLAGS0_OFFS, 32'h0000_0000);
		wr(FLAGS1_OFFS, 32'h0000_0000);
		outs();
		// pin edges under both polarities, every input at once
		for (int p = 0; p < 2; p++) begin
			wr(CTRL2_OFFS, p ? 32'h0000_801F : 32'h0000_0000);
			for (int k = 0; k < 2; k++) begin
				lvl <= k ? 5'h00 : 5'h1F;
				s = 5'h00;
				repeat (10) begin
					@(posedge clk);
					s = s | pulse;
				end
				chk({27'h0, s}, (k == p) ? 32'h0000_001F : 32'h0000_0000);
				if (k == p) begin
					m_f0 = m_f0 | FLAGS0_EXT;
					m_f1 = m_f1 | FLAGS1_EXT;
					m_st = 2'h3;
				end
				rd(FLAGS0_OFFS);
				rd(FLAGS1_OFFS);
				outs();
				wr(FLAGS0_OFFS, 32'h0000_0000);
				wr(FLAGS1_OFFS, 32'h0000_0000);
			end
		end
		// interrupt: raise masked, unmask, clear, other group
		wr(STAT_OFFS, 32'h0000_0003);
		wr(MASK_OFFS, 32'h0000_0000);
		fire(16'h0002, 16'h0000);
		rd(STAT_OFFS);
		outs();
		wr(MASK_OFFS, 32'h0000_0001);
		outs();
		wr(STAT_OFFS, 32'h0000_0001, 4'h2);
		outs();
		wr(STAT_OFFS, 32'h0000_0001);
		outs();
		rd(STAT_OFFS);
		rd(FLAGS0_OFFS);
		wr(MASK_OFFS, 32'h0000_0002);
		fire(16'h0000, 16'h0004);
		outs();
		wr(STAT_OFFS, 32'h0000_0002);
		rd(MASK_OFFS);
		outs();
		close_out();
	end
endmodule // irq_control_and_flag_regs_bench
`default_nettype wire
